/* include/bdp_map.svh */
// register indices, field positions, reset values and timing figures
`ifndef BDP_MAP_SVH
`define BDP_MAP_SVH
`define BDP_IDX_STATCTL 8'h51
`define BDP_IDX_MODE 8'h53
`define BDP_IDX_TIMING 8'h54
`define BDP_IDX_REFPER 8'h55
`define BDP_IDX_STATUS 8'h60
`define BDP_BURST_BIT 6
`define BDP_DRAM_BIT 0
`define BDP_CAS_HI_LSB 6
`define BDP_CAS_LO_LSB 4
`define BDP_RAS_HI_LSB 2
`define BDP_RAS_LO_LSB 0
`define BDP_RST_REG 8'h00
`define BDP_RST_REFPER 8'hff
`define BDP_RAS_LO_BASE 3'h2
`define BDP_FIELD_BASE 3'h1
`define BDP_GRP 3'h4
`define BDP_COL_LAST 10'h3ff
`define BDP_RESP_OKAY 2'h0
`define BDP_RESP_SLVERR 2'h2
`endif

/* include/bdp_pkg.sv */
// types shared by the buffer dram page burst controller
package bdp_pkg;
  // one requester's offer to the buffer
  typedef struct packed {
    logic valid;
    logic write;
    logic final_grp;
    logic [2:0] avail;
    logic [19:0] addr;
    logic [7:0] wdata;
  } bdp_req_t;
  // dram pins as driven by the controller
  typedef struct packed {
    logic row_strobe_addr_pin;
    logic column_strobe_addr_pin;
    logic memory_output_enable_n;
    logic write_enable_n;
    logic [9:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } bdp_dram_t;
  typedef enum logic [2:0] {S_IDLE, S_ROW, S_CAS_LO, S_CAS_HI, S_REF, S_PRECH} bdp_st_t;
  typedef enum logic [1:0] {SRC_HOST, SRC_FMT, SRC_MCU, SRC_REF} bdp_src_t;
endpackage

/* src/bdp_arb.sv */
// rotating choice among the host, formatter and microcontroller requests
`timescale 1ns/10ps
module bdp_arb
  import bdp_pkg::*;
(
  // eligible requesters and last winner
  input wire logic [2:0] elig,
  input wire logic [1:0] last,
  // choice
  output logic [1:0] pick,
  output logic any
);
  logic [2:0] sum;
  logic [1:0] k;

  // scan downward so the nearest follower of the last winner overwrites
  always_comb
  begin
    pick = last;
    any = 1'b0;
    sum = 3'h0;
    k = 2'h0;
    for (int i = 3; i >= 1; i--)
    begin
      sum = {1'b0, last} + 3'(i);
      k = (sum >= 3'h3) ? 2'(sum - 3'h3) : sum[1:0];
      if (elig[k])
      begin
        pick = k;
        any = 1'b1;
      end
    end
  end
endmodule

/* src/bdp_refresh.sv */
// refresh interval timer and refresh row counter
`timescale 1ns/10ps
module bdp_refresh
  import bdp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic enable,
  input wire logic [7:0] period,
  input wire logic done,
  // status
  output logic pend,
  output logic [8:0] row
);
  typedef struct packed {
    logic [8:0] cnt;
    logic pend;
    logic [8:0] row;
  } bdp_ref_st_t;
  bdp_ref_st_t s, next_s;

  // interval is the period with a one below it, in clocks
  always_comb
  begin
    next_s = s;
    // count runs from the interval less one down to zero, so ticks land exactly one interval apart
    if (!enable || s.cnt == 9'h000)
      next_s.cnt = {period, 1'b1} - 9'h001;
    else
      next_s.cnt = s.cnt - 9'h001;
    if (done)
    begin
      next_s.pend = 1'b0;
      next_s.row = s.row + 9'h001;
    end
    // a new tick wins over the clear
    if (enable && s.cnt == 9'h000)
      next_s.pend = 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign pend = s.pend;
  assign row = s.row;
endmodule

/* src/bdp_ctrl.sv */
// buffer dram page burst controller with its axi4-lite register slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "bdp_map.svh"
module bdp_ctrl
  import bdp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // buffer requesters
  input wire bdp_req_t host_req,
  input wire bdp_req_t fmt_req,
  input wire bdp_req_t mcu_req,
  // per byte answers: bit 0 host, 1 formatter, 2 microcontroller
  output logic [2:0] byte_ack,
  output logic [7:0] rd_data,
  // dram pins
  output bdp_dram_t dram,
  input wire logic [7:0] dq_in
);
  typedef struct packed {
    bdp_st_t st;
    bdp_src_t src;
    logic [1:0] last;
    logic wr;
    logic [2:0] left;
    logic [19:0] addr;
    logic [2:0] cnt;
    bdp_dram_t dram;
    logic [2:0] ack;
    logic [7:0] rd;
    logic ref_done;
    logic [7:0] statctl;
    logic [7:0] mode;
    logic [7:0] timing;
    logic [7:0] refper;
    logic awready;
    logic wready;
    logic [7:0] widx;
    logic [7:0] wd;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bdp_ctrl_st_t;
  bdp_ctrl_st_t s, next_s;

  logic ref_pend;
  logic [8:0] ref_row;
  logic [2:0] elig;
  logic [1:0] pick;
  logic pick_any;
  logic burst_en;
  logic dram_mode;

  // bytes a requester may move now, zero when it may not be granted
  function automatic logic [2:0] grant_len(bdp_req_t r, logic burst);
    logic [2:0] n;
    n = (r.avail > `BDP_GRP) ? `BDP_GRP : r.avail;
    if (!r.valid)
      n = 3'h0;
    else if (burst && n < `BDP_GRP && !r.final_grp)
      n = 3'h0;
    return n;
  endfunction

  // two-bit timing field plus its base, in clocks
  function automatic logic [2:0] fld(logic [7:0] t, int lsb, logic [2:0] base);
    return 3'(t[lsb +: 2]) + base;
  endfunction

  // register index from a byte address
  function automatic logic [7:0] idx_of(logic [11:0] a);
    return a[9:2];
  endfunction

  function automatic logic mapped(logic [11:0] a);
    logic [7:0] i;
    i = idx_of(a);
    return a[11:10] == 2'h0 && (i == `BDP_IDX_STATCTL || i == `BDP_IDX_MODE
      || i == `BDP_IDX_TIMING || i == `BDP_IDX_REFPER || i == `BDP_IDX_STATUS);
  endfunction

  assign burst_en = s.statctl[`BDP_BURST_BIT];
  assign dram_mode = s.mode[`BDP_DRAM_BIT];

  // eligibility for the rotating grant
  always_comb
  begin
    elig[SRC_HOST] = grant_len(host_req, burst_en) != 3'h0;
    elig[SRC_FMT] = grant_len(fmt_req, burst_en) != 3'h0;
    elig[SRC_MCU] = mcu_req.valid;
  end

  bdp_arb u_arb (
    .elig(elig),
    .last(s.last),
    .pick(pick),
    .any(pick_any)
  );

  bdp_refresh u_ref (
    .clk(clk),
    .resetn(resetn),
    .enable(dram_mode),
    .period(s.refper),
    .done(s.ref_done),
    .pend(ref_pend),
    .row(ref_row)
  );

  // sequencer and register slave share one next-state process
  always_comb
  begin
    bdp_req_t r;
    logic [2:0] n;
    r = host_req;
    n = 3'h0;
    next_s = s;
    next_s.ack = 3'h0;
    next_s.ref_done = 1'b0;

    // dram sequencer
    case (s.st)
      S_IDLE:
      begin
        if (dram_mode && ref_pend)
        begin
          // refresh wins, but only at a burst boundary
          next_s.st = S_REF;
          next_s.src = SRC_REF;
          next_s.dram.row_strobe_addr_pin = 1'b0;
          next_s.dram.addr = {1'b0, ref_row};
          next_s.dram.memory_output_enable_n = 1'b1;
          next_s.dram.write_enable_n = 1'b1;
          next_s.cnt = fld(s.timing, `BDP_RAS_LO_LSB, `BDP_RAS_LO_BASE) - 3'h1;
        end
        else if (dram_mode && pick_any)
        begin
          case (pick)
            SRC_HOST:
            begin
              r = host_req;
              n = grant_len(host_req, burst_en);
            end
            SRC_FMT:
            begin
              r = fmt_req;
              n = grant_len(fmt_req, burst_en);
            end
            default:
            begin
              r = mcu_req;
              n = 3'h1;
            end
          endcase
          next_s.st = S_ROW;
          next_s.src = bdp_src_t'(pick);
          next_s.last = pick;
          next_s.wr = r.write;
          next_s.left = n;
          next_s.addr = r.addr;
          next_s.dram.row_strobe_addr_pin = 1'b0;
          next_s.dram.addr = r.addr[19:10];
          next_s.dram.write_enable_n = !r.write;
          next_s.dram.dq_oe = r.write;
        end
      end
      S_ROW:
      begin
        // column strobe one clock after the row strobe
        next_s.st = S_CAS_LO;
        next_s.dram.column_strobe_addr_pin = 1'b0;
        next_s.dram.addr = s.addr[9:0];
        next_s.dram.memory_output_enable_n = s.wr;
        next_s.dram.dq_out = s.src == SRC_FMT ? fmt_req.wdata
          : s.src == SRC_MCU ? mcu_req.wdata : host_req.wdata;
        next_s.ack[s.src] = s.wr;
        // first column low is the row low time less one clock
        next_s.cnt = fld(s.timing, `BDP_RAS_LO_LSB, `BDP_RAS_LO_BASE) - 3'h2;
      end
      S_CAS_LO:
      begin
        if (s.cnt != 3'h0)
          next_s.cnt = s.cnt - 3'h1;
        else
        begin
          // a read byte moves at the end of its column low time; a write byte moved as the column fell
          next_s.ack[s.src] = !s.wr;
          if (!s.wr)
            next_s.rd = dq_in;
          next_s.left = s.left - 3'h1;
          next_s.addr = s.addr + 20'h0_0001;
          next_s.dram.column_strobe_addr_pin = 1'b1;
          if (s.left == 3'h1 || s.addr[9:0] == `BDP_COL_LAST)
          begin
            // both strobes and the enables end together
            next_s.st = S_PRECH;
            next_s.dram.row_strobe_addr_pin = 1'b1;
            next_s.dram.memory_output_enable_n = 1'b1;
            next_s.dram.write_enable_n = 1'b1;
            next_s.dram.dq_oe = 1'b0;
            next_s.cnt = fld(s.timing, `BDP_RAS_HI_LSB, `BDP_FIELD_BASE) - 3'h1;
          end
          else
          begin
            next_s.st = S_CAS_HI;
            next_s.cnt = fld(s.timing, `BDP_CAS_HI_LSB, `BDP_FIELD_BASE) - 3'h1;
          end
        end
      end
      S_CAS_HI:
      begin
        if (s.cnt != 3'h0)
          next_s.cnt = s.cnt - 3'h1;
        else
        begin
          // next byte of the page, same row
          next_s.st = S_CAS_LO;
          next_s.dram.column_strobe_addr_pin = 1'b0;
          next_s.dram.addr = s.addr[9:0];
          next_s.dram.dq_out = s.src == SRC_FMT ? fmt_req.wdata
            : s.src == SRC_MCU ? mcu_req.wdata : host_req.wdata;
          next_s.ack[s.src] = s.wr;
          next_s.cnt = fld(s.timing, `BDP_CAS_LO_LSB, `BDP_FIELD_BASE) - 3'h1;
        end
      end
      S_REF:
      begin
        if (s.cnt != 3'h0)
          next_s.cnt = s.cnt - 3'h1;
        else
        begin
          next_s.st = S_PRECH;
          next_s.dram.row_strobe_addr_pin = 1'b1;
          next_s.ref_done = 1'b1;
          next_s.cnt = fld(s.timing, `BDP_RAS_HI_LSB, `BDP_FIELD_BASE) - 3'h1;
        end
      end
      S_PRECH:
      begin
        // row precharge; idle adds one more clock, so this is a floor
        if (s.cnt != 3'h0)
          next_s.cnt = s.cnt - 3'h1;
        else
          next_s.st = S_IDLE;
      end
      default:
        next_s.st = S_IDLE;
    endcase

    // write address and data are taken in either order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.awready = 1'b0;
      next_s.widx = mapped(s_axi_awaddr) ? idx_of(s_axi_awaddr) : 8'h00;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.wready = 1'b0;
      next_s.wd = s_axi_wdata[7:0];
      next_s.wstb = s_axi_wstrb[0];
    end
    // commit once both halves are held
    if (!s.awready && !s.wready && !s.bvalid)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = `BDP_RESP_OKAY;
      case (s.widx)
        `BDP_IDX_STATCTL:
          if (s.wstb)
            next_s.statctl = s.wd;
        `BDP_IDX_MODE:
          if (s.wstb)
            next_s.mode = s.wd;
        `BDP_IDX_TIMING:
          if (s.wstb)
            next_s.timing = s.wd;
        `BDP_IDX_REFPER:
          if (s.wstb)
            next_s.refper = s.wd;
        default:
          next_s.bresp = `BDP_RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = `BDP_RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (!mapped(s_axi_araddr))
        next_s.rresp = `BDP_RESP_SLVERR;
      else
      begin
        case (idx_of(s_axi_araddr))
          `BDP_IDX_STATCTL:
            next_s.rdata[7:0] = s.statctl;
          `BDP_IDX_MODE:
            next_s.rdata[7:0] = s.mode;
          `BDP_IDX_TIMING:
            next_s.rdata[7:0] = s.timing;
          `BDP_IDX_REFPER:
            next_s.rdata[7:0] = s.refper;
          default:
            next_s.rdata[14:0] = {ref_row, ref_pend, s.src, s.st};
        endcase
      end
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // pins idle high, data bus released, slave ready
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.st <= S_IDLE;
      s.src <= SRC_HOST;
      s.last <= 2'h2;
      s.dram.row_strobe_addr_pin <= 1'b1;
      s.dram.column_strobe_addr_pin <= 1'b1;
      s.dram.memory_output_enable_n <= 1'b1;
      s.dram.write_enable_n <= 1'b1;
      s.statctl <= `BDP_RST_REG;
      s.mode <= `BDP_RST_REG;
      s.timing <= `BDP_RST_REG;
      s.refper <= `BDP_RST_REFPER;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end
    else
      s <= next_s;
  end

  // every output is a field of the registered state
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign byte_ack = s.ack;
  assign rd_data = s.rd;
  assign dram = s.dram;
endmodule

/* verif/bdp_ctrl_sva.sv */
// port assertions for the buffer dram page burst controller
`timescale 1ns/10ps
module bdp_ctrl_sva
  import bdp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write response
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // buffer side
  input wire logic [2:0] byte_ack,
  input wire bdp_dram_t dram
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [3:0] acks;
  // bytes acknowledged under one row strobe; a last read ack lands as the row rises
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      acks <= 4'h0;
    else if (dram.row_strobe_addr_pin)
      acks <= 4'h0;
    else
      acks <= acks + 4'(|byte_ack);
  property p_cas_in_row;
    !dram.column_strobe_addr_pin |-> !dram.row_strobe_addr_pin;
  endproperty
  a_cas_in_row: assert property (p_cas_in_row) else $error("column strobe outside row");
  property p_cas_lag;
    $fell(dram.column_strobe_addr_pin) |-> !$past(dram.row_strobe_addr_pin);
  endproperty
  a_cas_lag: assert property (p_cas_lag) else $error("column strobe before row");
  property p_oe_start;
    $fell(dram.memory_output_enable_n) |-> $fell(dram.column_strobe_addr_pin);
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("output enable fell alone");
  property p_oe_end;
    $rose(dram.memory_output_enable_n) |-> $rose(dram.column_strobe_addr_pin);
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("output enable rose alone");
  property p_we_start;
    $fell(dram.write_enable_n) |-> $fell(dram.row_strobe_addr_pin);
  endproperty
  a_we_start: assert property (p_we_start) else $error("write enable fell alone");
  property p_we_end;
    $rose(dram.write_enable_n) |-> $rose(dram.row_strobe_addr_pin);
  endproperty
  a_we_end: assert property (p_we_end) else $error("write enable rose alone");
  property p_row_prech;
    $rose(dram.row_strobe_addr_pin) |-> dram.row_strobe_addr_pin[*2];
  endproperty
  a_row_prech: assert property (p_row_prech) else $error("row precharge too short");
  property p_burst_max;
    acks <= 4'h4;
  endproperty
  a_burst_max: assert property (p_burst_max) else $error("burst above four bytes");
  property p_one_ack;
    $onehot0(byte_ack);
  endproperty
  a_one_ack: assert property (p_one_ack) else $error("two requesters served");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_dq_drive;
    dram.dq_oe |-> !dram.write_enable_n && dram.memory_output_enable_n;
  endproperty
  a_dq_drive: assert property (p_dq_drive) else $error("data driven outside a write");
endmodule
bind bdp_ctrl bdp_ctrl_sva u_sva (.clk(clk), .resetn(resetn), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .byte_ack(byte_ack), .dram(dram));

/* verif/bdp_dram_model.sv */
// behavioural page-mode dram behind the controller pins
`timescale 1ns/10ps
module bdp_dram_model
  import bdp_pkg::*;
(
  // pins from the controller
  input wire bdp_dram_t dram,
  // data back
  output logic [7:0] dq_in
);
  logic [7:0] mem [int];
  logic [9:0] row;
  initial dq_in = 8'h00;
  // row address taken as the row strobe falls
  always @(negedge dram.row_strobe_addr_pin)
    row = dram.addr;
  // byte stored as the column strobe falls under write enable
  always @(negedge dram.column_strobe_addr_pin)
    if (!dram.write_enable_n)
      mem[{row, dram.addr}] = dram.dq_out;
  // data only while column and output enable are low; otherwise a moving pattern
  always @(dram)
    if (!dram.column_strobe_addr_pin && !dram.memory_output_enable_n)
      dq_in = mem.exists({row, dram.addr}) ? mem[{row, dram.addr}] : 8'h00;
    else
      dq_in = ~dq_in;
endmodule

/* verif/tb_bdp_ctrl.sv */
// self-checking bench for the buffer dram page burst controller
`timescale 1ns/10ps
`include "bdp_map.svh"
module tb_bdp_ctrl
  import bdp_pkg::*;
;
  typedef struct {int w; bit wr; bit [2:0] av; bit fin; bit bur; bit [19:0] a; int n;} bdp_row_t;
  localparam logic [1:0] rsp_ok = `BDP_RESP_OKAY;
  localparam logic [1:0] rsp_err = `BDP_RESP_SLVERR;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] byte_ack;
  logic [7:0] rd_data, dq_in;
  bdp_dram_t dram;
  bdp_req_t rq [3] = '{default: '0};
  int mismatches, check_count, ol, cl, cyc, i, n;
  int t [3];
  logic [9:0] ra [3];
  logic [1:0] seq [8];
  // writes first, then reads of the same bytes
  bdp_row_t rows [9] = '{'{0, 1, 1, 0, 0, 20'h0_0100, 1}, '{1, 1, 6, 0, 1, 20'h0_0200, 4},
    '{0, 1, 2, 1, 1, 20'h0_0300, 2}, '{1, 1, 4, 0, 0, 20'h0_03fe, 2}, '{2, 1, 4, 0, 0, 20'h0_0400, 1},
    '{0, 0, 4, 0, 0, 20'h0_0200, 4}, '{1, 0, 3, 0, 1, 20'h0_0300, 0}, '{2, 0, 4, 0, 1, 20'h0_0400, 1},
    '{0, 0, 2, 0, 0, 20'h0_03fe, 2}};
  bdp_ctrl u_dut (.clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .host_req(rq[0]), .fmt_req(rq[1]), .mcu_req(rq[2]),
    .byte_ack(byte_ack), .rd_data(rd_data), .dram(dram), .dq_in(dq_in));
  bdp_dram_model u_mem (.dram(dram), .dq_in(dq_in));
  // clock, cycle count and strobe-low tallies
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    ol += int'(dram.memory_output_enable_n === 1'b0);
    cl += int'(dram.column_strobe_addr_pin === 1'b0);
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok)
    begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    chk(bresp === er, "write response");
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    chk(rresp === er && rdata === {24'h00_0000, d}, "read word");
    rready <= 1'b0;
  endtask
  // one request; valid drops after the first byte so only the granted group moves
  task automatic xfer(input int w, input bit wr_, input bit [2:0] av, input bit fin, input bit [19:0] a, input int e);
    int k;
    k = 0;
    @(posedge clk);
    rq[w] <= '{1'b1, wr_, fin, av, a, a[7:0] ^ 8'h5a};
    repeat (60)
    begin
      @(negedge clk);
      if (byte_ack[w] === 1'b1)
      begin
        chk(wr_ || rd_data === (8'(a + k) ^ 8'h5a), "read byte");
        k++;
        @(posedge clk);
        rq[w].valid <= 1'b0;
        rq[w].wdata <= 8'(a + k) ^ 8'h5a;
      end
    end
    @(posedge clk);
    rq[w].valid <= 1'b0;
    chk(k == e, "byte count");
  endtask
  // watchdog
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(12'h150, 8'h00, rsp_ok);
    rd(12'h154, 8'hff, rsp_ok);
    rd(12'h14c, 8'h00, rsp_ok);
    wr(12'h200, 8'h11, rsp_err);
    rd(12'h200, 8'h00, rsp_err);
    wr(12'h180, 8'h11, rsp_err);
    xfer(0, 1'b1, 3'h1, 1'b0, 20'h0_0100, 0);
    // ras low 5, cas low 3, cas high 2, ras high 2
    wr(12'h150, 8'h67, rsp_ok);
    rd(12'h150, 8'h67, rsp_ok);
    wr(12'h14c, 8'h01, rsp_ok);
    foreach (rows[k])
    begin
      wr(12'h144, {1'b0, rows[k].bur, 6'h00}, rsp_ok);
      xfer(rows[k].w, rows[k].wr, rows[k].av, rows[k].fin, rows[k].a, rows[k].n);
    end
    // strobe widths of a two-byte page read and of a single read
    ol = 0;
    cl = 0;
    xfer(0, 1'b0, 3'h2, 1'b0, 20'h0_0200, 2);
    chk(ol == 9 && cl == 7, "page strobe widths");
    ol = 0;
    cl = 0;
    xfer(0, 1'b0, 3'h1, 1'b0, 20'h0_0200, 1);
    chk(ol == 4 && cl == 4, "single strobe widths");
    // host and formatter contend: whole groups, served in turn
    @(posedge clk);
    rq[0] <= '{1'b1, 1'b0, 1'b0, 3'h4, 20'h0_0200, 8'h00};
    rq[1] <= '{1'b1, 1'b0, 1'b0, 3'h4, 20'h0_0200, 8'h00};
    n = 0;
    for (i = 0; i < 300 && n < 8; i++)
    begin
      @(negedge clk);
      if (byte_ack[1:0] !== 2'b00)
      begin
        seq[n] = byte_ack[1:0];
        n++;
      end
    end
    @(posedge clk);
    rq[0].valid <= 1'b0;
    rq[1].valid <= 1'b0;
    chk(n == 8 && seq[0] === seq[3] && seq[4] === seq[7] && seq[0] !== seq[4], "rotation");
    repeat (40) @(posedge clk);
    // refresh every 31 clocks, row-only, enables high, row counter stepping
    wr(12'h154, 8'h0f, rsp_ok);
    for (i = 0; i < 3; i++)
    begin
      @(negedge clk);
      while (dram.row_strobe_addr_pin !== 1'b0)
        @(negedge clk);
      t[i] = cyc;
      ra[i] = dram.addr;
      while (dram.row_strobe_addr_pin === 1'b0)
      begin
        chk(dram.column_strobe_addr_pin && dram.memory_output_enable_n && dram.write_enable_n, "refresh pins");
        @(negedge clk);
      end
    end
    chk(t[2] - t[1] == 31 && ra[2] === ra[1] + 10'h001, "refresh interval");
    // reset in mid access: pins back to idle, timing and mode registers cleared
    @(posedge clk);
    rq[0] <= '{1'b1, 1'b0, 1'b0, 3'h4, 20'h0_0200, 8'h00};
    repeat (6) @(posedge clk);
    resetn <= 1'b0;
    rq[0].valid <= 1'b0;
    @(negedge clk);
    chk(dram.row_strobe_addr_pin && dram.column_strobe_addr_pin && byte_ack === 3'h0, "reset pins");
    @(posedge clk);
    resetn <= 1'b1;
    rd(12'h150, 8'h00, rsp_ok);
    rd(12'h14c, 8'h00, rsp_ok);
    // status word: refresh row counter back at zero, sequencer idle
    rd(12'h180, 8'h00, rsp_ok);
    final_report();
  end
endmodule
